// ==== src/dsw_regs.vh ====
// Object indices, field positions, reset values and mode codes of the drive state word block.
`ifndef DSW_REGS_VH
`define DSW_REGS_VH

// ----------------------------------------------------------------------------
// Object dictionary indices and subindices
// ----------------------------------------------------------------------------
`define DSW_IDX_COMMAND 16'h6040
`define DSW_IDX_STATUS 16'h6041
`define DSW_IDX_VEL_TARGET 16'h6042
`define DSW_IDX_VEL_DEMAND 16'h6043
`define DSW_IDX_VEL_MEASURED 16'h6044
`define DSW_IDX_SPEED_LIMIT 16'h6046
`define DSW_SUB_ZERO 8'h00
`define DSW_SUB_LOWER 8'h01
`define DSW_SUB_UPPER 8'h02

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DSW_RST_COMMAND 16'h0000
`define DSW_RST_STATUS 16'h0000
`define DSW_RST_VEL_TARGET 16'h00c8
`define DSW_RST_VEL 16'h0000
`define DSW_LIMIT_ENTRIES 8'h02
`define DSW_RST_LOWER 32'h0000_0000
`define DSW_RST_UPPER 32'h0000_7530
`define DSW_ZERO32 32'h0000_0000

// ----------------------------------------------------------------------------
// Command word bit positions
// ----------------------------------------------------------------------------
`define DSW_CMD_SWITCH_ON 0
`define DSW_CMD_POWER_ENABLE 1
`define DSW_CMD_FAST_HALT_N 2
`define DSW_CMD_RUN_PERMIT 3
`define DSW_CMD_MS_LO 4
`define DSW_CMD_MS_HI 6
`define DSW_CMD_CLEAR_ERROR 7
`define DSW_CMD_HALT 8
`define DSW_CMD_MS_TOP 9

// ----------------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------------
`define DSW_ST_READY 0
`define DSW_ST_SWITCHED_ON 1
`define DSW_ST_OP_ENABLED 2
`define DSW_ST_FAULT 3
`define DSW_ST_POWER_APPLIED 4
`define DSW_ST_FAST_HALT_N 5
`define DSW_ST_INHIBIT 6
`define DSW_ST_WARNING 7
`define DSW_ST_SYNC 8
`define DSW_ST_EXTERNAL 9
`define DSW_ST_GOAL 10
`define DSW_ST_LIMIT 11
`define DSW_ST_MS_LO 12
`define DSW_ST_MS_HI 13
`define DSW_ST_SPARE 14
`define DSW_ST_FEEDBACK 15

// ----------------------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------------------
`define DSW_MODE_PROFILE_POS 8'h01
`define DSW_MODE_VELOCITY 8'h02
`define DSW_MODE_PROFILE_VEL 8'h03
`define DSW_MODE_PROFILE_TRQ 8'h04
`define DSW_MODE_INTERP_POS 8'h07

// ----------------------------------------------------------------------------
// Speed saturation bound of a signed 16-bit speed
// ----------------------------------------------------------------------------
`define DSW_SPEED_MAX 32'h0000_7fff

`endif

// ==== src/dsw_speed_clamp.v ====
// Velocity-mode target speed clamp against the lower and upper speed amounts.
`timescale 1ns/10ps

`include "dsw_regs.vh"

module dsw_speed_clamp (
  input wire [15:0] target_in,
  input wire [31:0] lower_in,
  input wire [31:0] upper_in,
  output reg [15:0] demand_out,
  output reg clamped_out
);

  // --------------------------------------------------------------------------
  // Magnitude compare, sign kept
  // --------------------------------------------------------------------------
  reg [31:0] magnitude;
  reg [31:0] chosen;
  reg [15:0] mag16;

  always @* begin
    magnitude = target_in[15] ? {16'h0000, 16'h0000 - target_in} : {16'h0000, target_in};
    chosen = magnitude;
    clamped_out = 1'b0;
    if (magnitude > upper_in) begin
      chosen = upper_in;
      clamped_out = 1'b1;
    end else if (magnitude < lower_in) begin
      chosen = lower_in;
      clamped_out = 1'b1;
    end
    // A limit above the signed 16-bit range saturates rather than wraps.
    if (chosen > `DSW_SPEED_MAX) begin
      chosen = `DSW_SPEED_MAX;
    end
    mag16 = chosen[15:0];
    demand_out = target_in[15] ? 16'h0000 - mag16 : mag16;
  end

endmodule // dsw_speed_clamp

// ==== src/dsw_top.v ====
// Drive command word decode, power state machine, status word and velocity limit.
`timescale 1ns/10ps

`include "dsw_regs.vh"

module dsw_top (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire od_req_in,
  input wire od_write_in,
  input wire [15:0] od_index_in,
  input wire [7:0] od_subindex_in,
  input wire [31:0] od_wdata_in,
  input wire [7:0] op_mode_in,
  input wire fault_in,
  input wire fault_react_done_in,
  input wire fast_halt_done_in,
  input wire warning_in,
  input wire sync_in,
  input wire goal_reached_in,
  input wire closed_loop_in,
  input wire [1:0] mode_status_bits_in,
  input wire [15:0] velocity_actual_in,
  output reg [31:0] od_rdata_out,
  output reg od_ack_out,
  output reg od_err_out,
  output reg [15:0] status_word_out,
  output reg [3:0] mode_specific_bits_out,
  output reg halt_out,
  output reg power_stage_on_out,
  output reg run_enable_out,
  output reg fast_halt_active_out,
  output reg fault_react_out,
  output reg [15:0] velocity_demand_out
);

  // --------------------------------------------------------------------------
  // Power state machine encoding
  // --------------------------------------------------------------------------
  localparam [2:0] ST_NOT_READY = 3'b000;
  localparam [2:0] ST_INHIBIT = 3'b001;
  localparam [2:0] ST_READY = 3'b010;
  localparam [2:0] ST_SWITCHED_ON = 3'b011;
  localparam [2:0] ST_OP_ENABLED = 3'b100;
  localparam [2:0] ST_FAST_HALT = 3'b101;
  localparam [2:0] ST_FAULT_REACT = 3'b110;
  localparam [2:0] ST_FAULT = 3'b111;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  reg [15:0] drive_command_word;
  reg [15:0] velocity_target;
  reg [15:0] velocity_measured;
  reg [31:0] speed_lower_limit;
  reg [31:0] speed_upper_limit;
  reg [2:0] state;
  reg [2:0] next_state;
  reg warning_latch;
  reg clear_prev;
  reg [15:0] next_status;

  wire switch_on_bit = drive_command_word[`DSW_CMD_SWITCH_ON];
  wire power_enable_bit = drive_command_word[`DSW_CMD_POWER_ENABLE];
  wire fast_halt_n = drive_command_word[`DSW_CMD_FAST_HALT_N];
  wire run_permit_bit = drive_command_word[`DSW_CMD_RUN_PERMIT];
  wire clear_error_bit = drive_command_word[`DSW_CMD_CLEAR_ERROR];
  wire halt_bit = drive_command_word[`DSW_CMD_HALT];

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  wire cmd_shutdown = power_enable_bit & fast_halt_n & ~switch_on_bit;
  wire cmd_switch_on = power_enable_bit & fast_halt_n & switch_on_bit & ~run_permit_bit;
  wire cmd_enable_op = power_enable_bit & fast_halt_n & switch_on_bit & run_permit_bit;
  wire cmd_disable_v = ~power_enable_bit;
  wire cmd_fast_halt = power_enable_bit & ~fast_halt_n;
  wire clear_edge = clear_error_bit & ~clear_prev;

  wire velocity_mode = (op_mode_in == `DSW_MODE_VELOCITY);
  wire halt_mode = (op_mode_in == `DSW_MODE_PROFILE_POS) | velocity_mode |
                   (op_mode_in == `DSW_MODE_PROFILE_VEL) | (op_mode_in == `DSW_MODE_PROFILE_TRQ) |
                   (op_mode_in == `DSW_MODE_INTERP_POS);

  // --------------------------------------------------------------------------
  // Velocity limit
  // --------------------------------------------------------------------------
  wire [15:0] clamp_demand;
  wire clamp_hit;

  dsw_speed_clamp u_clamp (
    .target_in(velocity_target),
    .lower_in(speed_lower_limit),
    .upper_in(speed_upper_limit),
    .demand_out(clamp_demand),
    .clamped_out(clamp_hit)
  );

  // --------------------------------------------------------------------------
  // Object dictionary decode
  // --------------------------------------------------------------------------
  reg hit;
  reg writable;
  reg [31:0] read_value;
  reg do_write;

  always @* begin
    hit = 1'b0;
    writable = 1'b0;
    read_value = `DSW_ZERO32;
    case (od_index_in)
      `DSW_IDX_COMMAND: begin
        hit = (od_subindex_in == `DSW_SUB_ZERO);
        writable = 1'b1;
        read_value = {16'h0000, drive_command_word};
      end
      `DSW_IDX_STATUS: begin
        hit = (od_subindex_in == `DSW_SUB_ZERO);
        read_value = {16'h0000, status_word_out};
      end
      `DSW_IDX_VEL_TARGET: begin
        hit = (od_subindex_in == `DSW_SUB_ZERO);
        writable = 1'b1;
        read_value = {16'h0000, velocity_target};
      end
      `DSW_IDX_VEL_DEMAND: begin
        hit = (od_subindex_in == `DSW_SUB_ZERO);
        read_value = {16'h0000, velocity_demand_out};
      end
      `DSW_IDX_VEL_MEASURED: begin
        hit = (od_subindex_in == `DSW_SUB_ZERO);
        read_value = {16'h0000, velocity_measured};
      end
      `DSW_IDX_SPEED_LIMIT: begin
        case (od_subindex_in)
          `DSW_SUB_ZERO: begin
            hit = 1'b1;
            read_value = {24'h00_0000, `DSW_LIMIT_ENTRIES};
          end
          `DSW_SUB_LOWER: begin
            hit = 1'b1;
            writable = 1'b1;
            read_value = speed_lower_limit;
          end
          `DSW_SUB_UPPER: begin
            hit = 1'b1;
            writable = 1'b1;
            read_value = speed_upper_limit;
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    do_write = od_req_in & od_write_in & hit & writable;
  end

  // --------------------------------------------------------------------------
  // Writable objects
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_command_word <= `DSW_RST_COMMAND;
      velocity_target <= `DSW_RST_VEL_TARGET;
      speed_lower_limit <= `DSW_RST_LOWER;
      speed_upper_limit <= `DSW_RST_UPPER;
    end else if (do_write) begin
      case (od_index_in)
        `DSW_IDX_COMMAND: begin
          drive_command_word <= od_wdata_in[15:0];
        end
        `DSW_IDX_VEL_TARGET: begin
          velocity_target <= od_wdata_in[15:0];
        end
        `DSW_IDX_SPEED_LIMIT: begin
          if (od_subindex_in == `DSW_SUB_LOWER) begin
            speed_lower_limit <= od_wdata_in;
          end else begin
            speed_upper_limit <= od_wdata_in;
          end
        end
        default: begin
          drive_command_word <= drive_command_word;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Access answer
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      od_ack_out <= 1'b0;
      od_err_out <= 1'b0;
      od_rdata_out <= `DSW_ZERO32;
    end else begin
      od_ack_out <= od_req_in;
      // Unknown objects and writes to read-only objects are refused.
      od_err_out <= od_req_in & (~hit | (od_write_in & ~writable));
      if (od_req_in & ~od_write_in & hit) begin
        od_rdata_out <= read_value;
      end else if (od_req_in) begin
        od_rdata_out <= `DSW_ZERO32;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power state machine
  // --------------------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_NOT_READY: begin
        next_state = ST_INHIBIT;
      end
      ST_INHIBIT: begin
        if (cmd_shutdown) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (cmd_disable_v | cmd_fast_halt) begin
          next_state = ST_INHIBIT;
        end else if (cmd_switch_on | cmd_enable_op) begin
          next_state = ST_SWITCHED_ON;
        end
      end
      ST_SWITCHED_ON: begin
        if (cmd_disable_v | cmd_fast_halt) begin
          next_state = ST_INHIBIT;
        end else if (cmd_shutdown) begin
          next_state = ST_READY;
        end else if (cmd_enable_op) begin
          next_state = ST_OP_ENABLED;
        end
      end
      ST_OP_ENABLED: begin
        if (cmd_disable_v) begin
          next_state = ST_INHIBIT;
        end else if (cmd_fast_halt) begin
          next_state = ST_FAST_HALT;
        end else if (cmd_shutdown) begin
          next_state = ST_READY;
        end else if (cmd_switch_on) begin
          next_state = ST_SWITCHED_ON;
        end
      end
      ST_FAST_HALT: begin
        if (cmd_disable_v | fast_halt_done_in) begin
          next_state = ST_INHIBIT;
        end
      end
      ST_FAULT_REACT: begin
        if (fault_react_done_in) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // The error clears only once its cause has gone.
        if (clear_edge & ~fault_in) begin
          next_state = ST_INHIBIT;
        end
      end
      default: begin
        next_state = ST_NOT_READY;
      end
    endcase
    if (fault_in & (state != ST_FAULT) & (state != ST_FAULT_REACT)) begin
      next_state = ST_FAULT_REACT;
    end
  end

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_NOT_READY;
      clear_prev <= 1'b0;
      warning_latch <= 1'b0;
      velocity_measured <= `DSW_RST_VEL;
    end else begin
      state <= next_state;
      clear_prev <= clear_error_bit;
      velocity_measured <= velocity_actual_in;
      // A new warning wins over a clear in the same cycle.
      if (warning_in) begin
        warning_latch <= 1'b1;
      end else if (clear_edge) begin
        warning_latch <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status word assembly
  // --------------------------------------------------------------------------
  always @* begin
    next_status = `DSW_RST_STATUS;
    case (next_state)
      ST_INHIBIT: begin
        next_status[`DSW_ST_INHIBIT] = 1'b1;
      end
      ST_READY: begin
        next_status[`DSW_ST_READY] = 1'b1;
        next_status[`DSW_ST_FAST_HALT_N] = 1'b1;
        next_status[`DSW_ST_POWER_APPLIED] = 1'b1;
      end
      ST_SWITCHED_ON: begin
        next_status[`DSW_ST_READY] = 1'b1;
        next_status[`DSW_ST_SWITCHED_ON] = 1'b1;
        next_status[`DSW_ST_FAST_HALT_N] = 1'b1;
        next_status[`DSW_ST_POWER_APPLIED] = 1'b1;
      end
      ST_OP_ENABLED: begin
        next_status[`DSW_ST_READY] = 1'b1;
        next_status[`DSW_ST_SWITCHED_ON] = 1'b1;
        next_status[`DSW_ST_OP_ENABLED] = 1'b1;
        next_status[`DSW_ST_FAST_HALT_N] = 1'b1;
        next_status[`DSW_ST_POWER_APPLIED] = 1'b1;
        next_status[`DSW_ST_FEEDBACK] = closed_loop_in;
      end
      ST_FAST_HALT: begin
        next_status[`DSW_ST_READY] = 1'b1;
        next_status[`DSW_ST_SWITCHED_ON] = 1'b1;
        next_status[`DSW_ST_OP_ENABLED] = 1'b1;
        next_status[`DSW_ST_POWER_APPLIED] = 1'b1;
      end
      ST_FAULT_REACT: begin
        next_status[`DSW_ST_READY] = 1'b1;
        next_status[`DSW_ST_SWITCHED_ON] = 1'b1;
        next_status[`DSW_ST_OP_ENABLED] = 1'b1;
        next_status[`DSW_ST_FAULT] = 1'b1;
      end
      ST_FAULT: begin
        next_status[`DSW_ST_FAULT] = 1'b1;
      end
      default: begin
        next_status[`DSW_ST_READY] = 1'b0;
      end
    endcase
    next_status[`DSW_ST_WARNING] = warning_latch | warning_in;
    next_status[`DSW_ST_SYNC] = sync_in;
    next_status[`DSW_ST_EXTERNAL] = 1'b1;
    next_status[`DSW_ST_GOAL] = goal_reached_in;
    next_status[`DSW_ST_LIMIT] = velocity_mode & clamp_hit;
    next_status[`DSW_ST_MS_HI:`DSW_ST_MS_LO] = mode_status_bits_in;
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_word_out <= `DSW_RST_STATUS;
      mode_specific_bits_out <= 4'h0;
      halt_out <= 1'b0;
      power_stage_on_out <= 1'b0;
      run_enable_out <= 1'b0;
      fast_halt_active_out <= 1'b0;
      fault_react_out <= 1'b0;
      velocity_demand_out <= `DSW_RST_VEL;
    end else begin
      status_word_out <= next_status;
      mode_specific_bits_out <= {drive_command_word[`DSW_CMD_MS_TOP],
                                 drive_command_word[`DSW_CMD_MS_HI:`DSW_CMD_MS_LO]};
      halt_out <= halt_bit & halt_mode;
      power_stage_on_out <= (next_state == ST_SWITCHED_ON) | (next_state == ST_OP_ENABLED) |
                            (next_state == ST_FAST_HALT);
      run_enable_out <= (next_state == ST_OP_ENABLED);
      fast_halt_active_out <= (next_state == ST_FAST_HALT);
      fault_react_out <= (next_state == ST_FAULT_REACT);
      velocity_demand_out <= velocity_mode ? clamp_demand : `DSW_RST_VEL;
    end
  end

endmodule // dsw_top

// ==== bench/dsw_checker.sv ====
// Concurrent checks on the ports of the drive state word block.
`timescale 1ns/10ps
module dsw_checker (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire od_req_in,
  input wire od_write_in,
  input wire [15:0] od_index_in,
  input wire [7:0] op_mode_in,
  input wire sync_in,
  input wire [1:0] mode_status_bits_in,
  input wire od_ack_out,
  input wire od_err_out,
  input wire [15:0] status_word_out,
  input wire [15:0] velocity_demand_out
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  ack_latency_a: assert property (od_req_in |=> od_ack_out)
    else $error("no answer one cycle after a request");
  ack_cause_a: assert property (od_ack_out |-> $past(od_req_in))
    else $error("answer without a request");
  err_with_ack_a: assert property (od_err_out |-> od_ack_out)
    else $error("refusal outside an answer");
  ro_write_err_a: assert property (od_req_in && od_write_in && od_index_in == 16'h6044 |=> od_err_out)
    else $error("write to measured speed not refused");
  remote_flag_a: assert property ($past(resetn_in) |-> status_word_out[9])
    else $error("remote flag low");
  sync_follow_a: assert property ($past(resetn_in) |-> status_word_out[8] == $past(sync_in))
    else $error("sync flag does not follow input");
  ms_status_a: assert property ($past(resetn_in) |-> status_word_out[13:12] == $past(mode_status_bits_in))
    else $error("mode status bits not passed through");
  loop_flag_a: assert property (status_word_out[15] |-> (status_word_out[6:0] & 7'h6f) == 7'h27)
    else $error("closed loop flag outside operation enabled");
  switched_code_a: assert property (status_word_out[1] && !status_word_out[3] |-> status_word_out[0] && !status_word_out[6])
    else $error("switched on flag with bad state code");
  demand_mode_a: assert property ($past(op_mode_in) != 8'h02 |-> velocity_demand_out == 16'h0000)
    else $error("speed demand outside velocity mode");
endmodule // dsw_checker

// ==== bench/dsw_master.sv ====
// Fieldbus master model that performs object reads and writes.
`timescale 1ns/10ps
module dsw_master (
  input wire clk_sys_in,
  input wire ack_in,
  input wire err_in,
  input wire [31:0] rdata_in,
  output reg req_out,
  output reg write_out,
  output reg [15:0] index_out,
  output reg [7:0] subindex_out,
  output reg [31:0] wdata_out
);
  // --------------
  // Object access
  // --------------
  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    index_out = 16'h0000;
    subindex_out = 8'h00;
    wdata_out = 32'h0000_0000;
  end
  // The request is a one-cycle pulse; address and data are driven inverted once it is taken.
  task access(input wr, input [15:0] idx, input [7:0] sub, input [31:0] wd, output [31:0] rd, output err);
    integer k;
    begin
      rd = 32'hxxxx_xxxx;
      err = 1'bx;
      @(posedge clk_sys_in);
      req_out <= 1'b1;
      write_out <= wr;
      index_out <= idx;
      subindex_out <= sub;
      wdata_out <= wd;
      @(posedge clk_sys_in);
      req_out <= 1'b0;
      index_out <= ~idx;
      subindex_out <= ~sub;
      wdata_out <= ~wd;
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk_sys_in);
        if (ack_in === 1'b1) begin
          rd = rdata_in;
          err = err_in;
          k = 4;
        end
      end
    end
  endtask
endmodule // dsw_master

// ==== bench/testbench.sv ====
// Self-checking bench of the drive state word block.
`timescale 1ns/10ps
module testbench;
  reg clk_sys_in, resetn_in, fault_in, fault_react_done_in, fast_halt_done_in, warning_in;
  reg sync_in, goal_reached_in, closed_loop_in, err;
  reg [7:0] op_mode_in;
  reg [1:0] mode_status_bits_in;
  reg [15:0] velocity_actual_in, t;
  reg [16:0] e;
  reg [31:0] rd, lo, hi;
  wire od_req_in, od_write_in, od_ack_out, od_err_out, halt_out, power_stage_on_out, run_enable_out;
  wire fast_halt_active_out, fault_react_out;
  wire [15:0] od_index_in, status_word_out, velocity_demand_out;
  wire [7:0] od_subindex_in;
  wire [31:0] od_wdata_in, od_rdata_out;
  wire [3:0] mode_specific_bits_out;
  integer n_mismatch, n_tests, seed, i;
  dsw_top u_dsw_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .od_req_in(od_req_in),
    .od_write_in(od_write_in), .od_index_in(od_index_in), .od_subindex_in(od_subindex_in),
    .od_wdata_in(od_wdata_in), .op_mode_in(op_mode_in), .fault_in(fault_in),
    .fault_react_done_in(fault_react_done_in), .fast_halt_done_in(fast_halt_done_in),
    .warning_in(warning_in), .sync_in(sync_in), .goal_reached_in(goal_reached_in),
    .closed_loop_in(closed_loop_in), .mode_status_bits_in(mode_status_bits_in),
    .velocity_actual_in(velocity_actual_in), .od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out),
    .od_err_out(od_err_out), .status_word_out(status_word_out), .mode_specific_bits_out(mode_specific_bits_out),
    .halt_out(halt_out), .power_stage_on_out(power_stage_on_out), .run_enable_out(run_enable_out),
    .fast_halt_active_out(fast_halt_active_out), .fault_react_out(fault_react_out),
    .velocity_demand_out(velocity_demand_out));
  dsw_master u_dsw_master (.clk_sys_in(clk_sys_in), .ack_in(od_ack_out), .err_in(od_err_out),
    .rdata_in(od_rdata_out), .req_out(od_req_in), .write_out(od_write_in), .index_out(od_index_in),
    .subindex_out(od_subindex_in), .wdata_out(od_wdata_in));
  // -------------
  // Helpers
  // -------------
  function [16:0] clamp(input [15:0] tv, input [31:0] mn, input [31:0] mx);
    reg [31:0] m, r;
    begin
      m = tv[15] ? {16'h0000, -tv} : {16'h0000, tv};
      r = (m > mx) ? mx : ((m < mn) ? mn : m);
      clamp = {r != m, tv[15] ? -r[15:0] : r[15:0]};
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task wr(input [15:0] idx, input [7:0] sub, input [31:0] d);
    begin
      u_dsw_master.access(1'b1, idx, sub, d, rd, err);
      repeat (3) @(posedge clk_sys_in);
    end
  endtask
  task rd_chk(input [15:0] idx, input [7:0] sub, input [31:0] exp);
    begin
      u_dsw_master.access(1'b0, idx, sub, 32'h0000_0000, rd, err);
      check(rd, exp);
      check(err, 1'b0);
    end
  endtask
  task st(input [15:0] mask, input [15:0] exp);
    check(status_word_out & mask, exp);
  endtask
  // -------------
  // Stimulus and checks
  // -------------
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  initial begin
    seed = 42;
    n_mismatch = 0;
    n_tests = 0;
    {resetn_in, fault_in, fault_react_done_in, fast_halt_done_in, warning_in} = 5'h00;
    {sync_in, goal_reached_in, closed_loop_in, mode_status_bits_in} = 5'h00;
    op_mode_in = 8'h00;
    velocity_actual_in = 16'h0000;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    st(16'hffff, 16'h0240);
    rd_chk(16'h6040, 8'h00, 32'h0000_0000);
    rd_chk(16'h6042, 8'h00, 32'h0000_00c8);
    rd_chk(16'h6043, 8'h00, 32'h0000_0000);
    rd_chk(16'h6044, 8'h00, 32'h0000_0000);
    rd_chk(16'h6046, 8'h00, 32'h0000_0002);
    rd_chk(16'h6046, 8'h01, 32'h0000_0000);
    rd_chk(16'h6046, 8'h02, 32'h0000_7530);
    u_dsw_master.access(1'b1, 16'h6044, 8'h00, 32'h0000_1234, rd, err);
    check(err, 1'b1);
    u_dsw_master.access(1'b1, 16'h6046, 8'h00, 32'h0000_0005, rd, err);
    check(err, 1'b1);
    u_dsw_master.access(1'b0, 16'h6045, 8'h00, 32'h0000_0000, rd, err);
    check({rd[30:0], err}, 32'h0000_0001);
    wr(16'h6040, 8'h00, 32'h0000_0006);
    st(16'h007f, 16'h0031);
    wr(16'h6040, 8'h00, 32'h0000_0007);
    st(16'h007f, 16'h0033);
    check(power_stage_on_out, 1'b1);
    closed_loop_in <= 1'b1;
    wr(16'h6040, 8'h00, 32'h0000_000f);
    st(16'h807f, 16'h8037);
    check(run_enable_out, 1'b1);
    wr(16'h6040, 8'h00, 32'h0000_000b);
    st(16'h806f, 16'h0007);
    check(fast_halt_active_out, 1'b1);
    fast_halt_done_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    st(16'h004f, 16'h0040);
    check({power_stage_on_out, fast_halt_active_out}, 2'b00);
    fast_halt_done_in <= 1'b0;
    warning_in <= 1'b1;
    fault_in <= 1'b1;
    @(posedge clk_sys_in);
    warning_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    st(16'h00cf, 16'h008f);
    check(fault_react_out, 1'b1);
    fault_react_done_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    st(16'h004f, 16'h0008);
    {fault_in, fault_react_done_in} <= 2'b00;
    wr(16'h6040, 8'h00, 32'h0000_0000);
    wr(16'h6040, 8'h00, 32'h0000_0080);
    st(16'h00cf, 16'h0040);
    for (i = 0; i < 16; i = i + 1) begin
      t = $random(seed);
      op_mode_in <= {5'h00, i[2:0]};
      mode_status_bits_in <= t[13:12];
      wr(16'h6040, 8'h00, {22'h000000, t[9], i[3], 1'b0, t[6:4], 4'h0});
      check(halt_out, i[3] & (i[2:0] != 3'd0) & (i[2:0] != 3'd5) & (i[2:0] != 3'd6));
      check(mode_specific_bits_out, {t[9], t[6:4]});
      st(16'h3000, {2'b00, t[13:12], 12'h000});
    end
    op_mode_in <= 8'h02;
    for (i = 0; i < 12; i = i + 1) begin
      lo = $random(seed) & 32'h0000_0fff;
      hi = lo + ($random(seed) & 32'h0000_0fff);
      t = $random(seed);
      t = (i == 0) ? 16'h8000 : (i == 1) ? hi[15:0] : (i == 2) ? -lo[15:0] : {{4{t[15]}}, t[11:0]};
      {sync_in, goal_reached_in} <= t[1:0];
      velocity_actual_in <= t ^ 16'h5a5a;
      wr(16'h6046, 8'h01, lo);
      wr(16'h6046, 8'h02, hi);
      wr(16'h6042, 8'h00, {16'h0000, t});
      e = clamp(t, lo, hi);
      check(velocity_demand_out, e[15:0]);
      st(16'h0f00, {4'h0, e[16], t[0], 1'b1, t[1], 8'h00});
      rd_chk(16'h6043, 8'h00, {16'h0000, e[15:0]});
      rd_chk(16'h6044, 8'h00, {16'h0000, t ^ 16'h5a5a});
    end
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    st(16'h02ff, 16'h0240);
    rd_chk(16'h6042, 8'h00, 32'h0000_00c8);
    stop_test;
  end
endmodule // testbench
bind dsw_top dsw_checker u_dsw_checker (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .od_req_in(od_req_in),
  .od_write_in(od_write_in), .od_index_in(od_index_in), .op_mode_in(op_mode_in), .sync_in(sync_in),
  .mode_status_bits_in(mode_status_bits_in), .od_ack_out(od_ack_out), .od_err_out(od_err_out),
  .status_word_out(status_word_out), .velocity_demand_out(velocity_demand_out));
